// File: verif/puc_chk_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "puc_map.vh"
module puc_chk #(
	parameter CNT_W = 16,
	parameter PRE_W = 10
) (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        irq_q
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [7:0] ra_q;
	logic [2:0] ien_q;
	logic       run_q;
	wire        wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready;
	// Shadows of the read address and of the IEN and RUN values software wrote, so reads can be judged later.
	always @(posedge aclk) begin
		if (!aresetn) begin
			ra_q <= 8'h00;
			ien_q <= 3'h0;
			run_q <= 1'b0;
		end else begin
			if (s_axi_arvalid && s_axi_arready)
				ra_q <= s_axi_araddr;
			if (wr_go && s_axi_awaddr == `PUC_ADDR_IEN)
				ien_q <= s_axi_wdata[2:0];
			if (wr_go && s_axi_awaddr == `PUC_ADDR_RUN)
				run_q <= s_axi_wdata[0];
		end
	end
	property p_bh; s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_bh: assert property (p_bh) else $error("bresp dropped");
	property p_rh; s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rh: assert property (p_rh) else $error("rdata dropped");
	// Both halves are held one edge before the response is raised.
	property p_bq; wr_go |-> ##2 s_axi_bvalid; endproperty
	a_bq: assert property (p_bq) else $error("late bvalid");
	property p_rq; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rq: assert property (p_rq) else $error("late rvalid");
	property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_busy: assert property (p_busy) else $error("ready early");
	property p_cw; s_axi_rvalid && ra_q == `PUC_ADDR_CNT |->
		s_axi_rdata[31:16] == 16'h0000; endproperty
	a_cw: assert property (p_cw) else $error("count too wide");
	property p_stop; s_axi_rvalid && ra_q == `PUC_ADDR_CNT && !run_q |->
		s_axi_rdata == 32'h0000_0000; endproperty
	a_stop: assert property (p_stop) else $error("stopped nonzero");
	property p_irq; ien_q == 3'h0 && $past(ien_q) == 3'h0 &&
		$past(ien_q, 3) == 3'h0 |-> !irq_q; endproperty
	a_irq: assert property (p_irq) else $error("masked irq");
	c_irq: cover property ($rose(irq_q));
	c_err: cover property (s_axi_bvalid && s_axi_bresp == `PUC_RESP_SLVERR);
	c_stop: cover property (s_axi_rvalid && !run_q);
endmodule
bind puc_timer puc_chk #(.CNT_W(CNT_W), .PRE_W(PRE_W)) u_chk (.aclk,
	.aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq_q);
`default_nettype wire

// File: verif/test_prescaled_up_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "puc_map.vh"
module test_prescaled_up_counter;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, external_count_pin, irq_q;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, v, u;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	int          mismatches = 0, checks = 0, cyc = 0, t0, t1, e;
	puc_timer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_count_pin,
		.irq_q);
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	task automatic results;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// The overflow wait alone needs 65536 cycles, hence the high ceiling.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			mismatches++;
			results;
		end
	end
	task automatic chk(input string n, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready && s_axi_arvalid) t1 = cyc;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		v = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// Phase of the tick against the read is unknown, so allow one tick.
	task automatic rate(input logic [2:0] p, input logic [1:0] s, input int n);
		// Rates are only reconfigured while the timer is stopped.
		wr(`PUC_ADDR_RUN, 32'h0000_0000);
		wr(`PUC_ADDR_PRE, {29'h0, p});
		wr(`PUC_ADDR_MODE, {30'h0, s});
		wr(`PUC_ADDR_RUN, 32'h0000_0003);
		rd(`PUC_ADDR_CNT);
		u = v;
		t0 = t1;
		repeat (200) @(posedge aclk);
		rd(`PUC_ADDR_CNT);
		e = (t1 - t0) / n;
		chk("ticks", {31'h0, v - u + 1 >= e && v - u <= e + 1}, 1);
	endtask
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, external_count_pin} = 3'h0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hF;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`PUC_ADDR_CNT);
		chk("cnt", v, 0);
		rd(`PUC_ADDR_STAT);
		chk("stat", v, 0);
		$display("test reset done");
		for (int s = 0; s < 6; s++)
			rate(3'(s), `PUC_SRC_DIV1, 1 << s);
		rate(3'h0, `PUC_SRC_DIV4, 4);
		rate(3'h0, `PUC_SRC_DIV16, 16);
		wr(`PUC_ADDR_RUN, 32'h0000_0002);
		rd(`PUC_ADDR_CNT);
		chk("stopped", v, 0);
		wr(`PUC_ADDR_RUN, 32'h0000_0001);
		repeat (50) @(posedge aclk);
		rd(`PUC_ADDR_CNT);
		chk("no prescaler", v, 0);
		$display("test rates done");
		wr(`PUC_ADDR_RUN, 32'h0000_0000);
		wr(`PUC_ADDR_MODE, {30'h0, `PUC_SRC_PIN});
		wr(`PUC_ADDR_RUN, 32'h0000_0003);
		repeat (5) begin
			repeat (3) @(posedge aclk);
			external_count_pin <= 1'b1;
			repeat (3) @(posedge aclk);
			external_count_pin <= 1'b0;
		end
		repeat (8) @(posedge aclk);
		rd(`PUC_ADDR_CNT);
		chk("pin", v, 5);
		$display("test pin done");
		wr(`PUC_ADDR_RUN, 32'h0000_0000);
		wr(`PUC_ADDR_RG0, 32'h0000_0005);
		wr(`PUC_ADDR_RG1, 32'h0000_000A);
		wr(`PUC_ADDR_MODE, 32'h0000_0004);
		wr(`PUC_ADDR_IEN, 32'h0000_0003);
		wr(`PUC_ADDR_RUN, 32'h0000_0003);
		repeat (40) @(posedge aclk);
		rd(`PUC_ADDR_CNT);
		chk("cleared", {31'h0, v < 10}, 1);
		rd(`PUC_ADDR_STAT);
		chk("flags", v, 3);
		chk("irq", irq_q, 1);
		wr(`PUC_ADDR_IEN, 32'h0000_0000);
		repeat (3) @(posedge aclk);
		chk("masked", irq_q, 0);
		wr(`PUC_ADDR_RUN, 32'h0000_0000);
		wr(`PUC_ADDR_ICLR, 32'h0000_0007);
		rd(`PUC_ADDR_STAT);
		chk("cleared flags", v, 0);
		$display("test match done");
		wr(`PUC_ADDR_MODE, 32'h0000_0000);
		wr(`PUC_ADDR_IEN, 32'h0000_0004);
		wr(`PUC_ADDR_RUN, 32'h0000_0003);
		repeat (30) @(posedge aclk);
		rd(`PUC_ADDR_CNT);
		chk("free", {31'h0, v > 10}, 1);
		wait (irq_q === 1'b1);
		rd(`PUC_ADDR_CNT);
		chk("wrapped", {31'h0, v < 16}, 1);
		rd(`PUC_ADDR_STAT);
		chk("overflow", {31'h0, v[2]}, 1);
		$display("test overflow done");
		wr(8'h7C, 32'h0000_0001);
		chk("bad write", r, `PUC_RESP_SLVERR);
		rd(8'h7C);
		chk("bad read", r, `PUC_RESP_SLVERR);
		wr(`PUC_ADDR_CNT, 32'h0000_0001);
		chk("cnt write", r, `PUC_RESP_SLVERR);
		$display("test errors done");
		results;
	end
endmodule
`default_nettype wire

// File: verilog/puc_map.vh
// Overview of operation
// - Prescaler select codes 000..101 pick periph clock divided by 1,2,4,8,16,32.
// - The up-counter is a 16-bit binary counter.
// - Two-bit source select picks tick div1, div4, div16 or external pin.
// - Writing 1 to the counter run bit starts counting.
// - Writing 0 to the counter run bit stops and clears the counter.
// - Counter equal to compare 0 or 1 raises that match interrupt.
// - With clear enable 1, a match on compare 1 clears the counter.
// - With clear enable 0, the counter runs free.
// - Prescaler run bit 1 enables the prescaler; 0 stops and clears it.
// - Counter overflow past its maximum raises an overflow interrupt.
`ifndef PUC_MAP_VH
`define PUC_MAP_VH
`define PUC_ADDR_RUN    8'h04
`define PUC_ADDR_MODE   8'h08
`define PUC_ADDR_PRE    8'h0C
`define PUC_ADDR_RG0    8'h20
`define PUC_ADDR_RG1    8'h24
`define PUC_ADDR_CNT    8'h2C
`define PUC_ADDR_STAT   8'h30
`define PUC_ADDR_IEN    8'h34
`define PUC_ADDR_ICLR   8'h38
`define PUC_RUN_CNT     0
`define PUC_RUN_PRE     1
`define PUC_MODE_SRC_LO 0
`define PUC_MODE_SRC_HI 1
`define PUC_MODE_CLE    2
`define PUC_IRQ_M0      0
`define PUC_IRQ_M1      1
`define PUC_IRQ_OVF     2
`define PUC_SRC_DIV1    2'h0
`define PUC_SRC_DIV4    2'h1
`define PUC_SRC_DIV16   2'h2
`define PUC_SRC_PIN     2'h3
`define PUC_RESP_OKAY   2'h0
`define PUC_RESP_SLVERR 2'h2
`endif

// File: verilog/puc_timer.v
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "puc_map.vh"
module puc_timer #(
	parameter CNT_W = 16,
	parameter PRE_W = 10
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        external_count_pin,
	output reg         irq_q
);
	reg             counter_run_bit_q;
	reg             prescaler_run_bit_q;
	reg [1:0]       count_source_select_q;
	reg             match1_clear_enable_q;
	reg [2:0]       pre_sel_q;
	reg [CNT_W-1:0] compare_reg_0_q;
	reg [CNT_W-1:0] compare_reg_1_q;
	reg [CNT_W-1:0] up_count_value_q;
	reg [2:0]       stat_q;
	reg [2:0]       ien_q;
	reg [PRE_W-1:0] pre_q;
	reg [PRE_W-1:0] pre_prev_q;
	reg [2:0]       pin_sync_q;
	reg             pin_level_q;
	reg [7:0]       aw_addr_q;
	reg [31:0]      w_data_q;
	reg [3:0]       w_strb_q;
	reg             aw_have_q;
	reg             w_have_q;

	// At selects 1 to 5, the selected periph rate is a falling edge of one prescaler bit; selects 6 and 7 give no tick.
	wire [PRE_W-1:0] pre_fall = pre_prev_q & ~pre_q;
	reg              tick_base;
	reg              tick_div1;
	reg              tick_div4;
	reg              tick_div16;
	reg              tick_sel;
	wire             pin_rise;
	wire             do_write = aw_have_q && w_have_q && !s_axi_bvalid;
	wire             wr_ok;
	wire [CNT_W-1:0] cnt_inc = up_count_value_q + {{(CNT_W-1){1'b0}}, 1'b1};
	wire             cnt_max = &up_count_value_q;
	wire             hit0;
	wire             hit1;
	wire             ovf_ev;
	wire [2:0]       ev;
	reg  [31:0]      rd_data;
	reg              rd_ok;

	// A free-running stage divides by 1; pre_fall on bit n gives /2^(n+1).
	always @* begin
		case (pre_sel_q)
		3'h0: tick_base = prescaler_run_bit_q;
		3'h1: tick_base = pre_fall[0];
		3'h2: tick_base = pre_fall[1];
		3'h3: tick_base = pre_fall[2];
		3'h4: tick_base = pre_fall[3];
		3'h5: tick_base = pre_fall[4];
		default: tick_base = 1'b0;
		endcase
	end

	// Slower ticks are taken two and four stages further up.
	always @* begin
		tick_div1 = tick_base;
		case (pre_sel_q)
		3'h0: begin
			tick_div4  = pre_fall[1];
			tick_div16 = pre_fall[3];
		end
		3'h1: begin
			tick_div4  = pre_fall[2];
			tick_div16 = pre_fall[4];
		end
		3'h2: begin
			tick_div4  = pre_fall[3];
			tick_div16 = pre_fall[5];
		end
		3'h3: begin
			tick_div4  = pre_fall[4];
			tick_div16 = pre_fall[6];
		end
		3'h4: begin
			tick_div4  = pre_fall[5];
			tick_div16 = pre_fall[7];
		end
		3'h5: begin
			tick_div4  = pre_fall[6];
			tick_div16 = pre_fall[8];
		end
		default: begin
			tick_div4  = 1'b0;
			tick_div16 = 1'b0;
		end
		endcase
	end

	// Pin edge counts once the second and third stages agree high.
	assign pin_rise = pin_sync_q[1] && pin_sync_q[2] && !pin_level_q;

	always @* begin
		case (count_source_select_q)
		`PUC_SRC_DIV1:  tick_sel = tick_div1;
		`PUC_SRC_DIV4:  tick_sel = tick_div4;
		`PUC_SRC_DIV16: tick_sel = tick_div16;
		default:        tick_sel = pin_rise;
		endcase
	end

	// Matches are events on entry to the value, so a stopped counter at a
	// compare value does not raise the flag again every cycle.
	wire step = counter_run_bit_q && tick_sel;
	wire clr1 = match1_clear_enable_q && (cnt_inc == compare_reg_1_q);
	assign hit0   = step && (cnt_inc == compare_reg_0_q);
	assign hit1   = step && (cnt_inc == compare_reg_1_q);
	assign ovf_ev = step && cnt_max && !clr1;
	assign ev     = {ovf_ev, hit1, hit0};

	always @(posedge aclk) begin
		if (!aresetn) begin
			pre_q      <= {PRE_W{1'b0}};
			pre_prev_q <= {PRE_W{1'b0}};
		end else if (!prescaler_run_bit_q) begin
			pre_q      <= {PRE_W{1'b0}};
			pre_prev_q <= {PRE_W{1'b0}};
		end else begin
			pre_q      <= pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
			pre_prev_q <= pre_q;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_sync_q  <= 3'h0;
			pin_level_q <= 1'b0;
		end else begin
			pin_sync_q <= {pin_sync_q[1:0], external_count_pin};
			if (pin_sync_q[1] == pin_sync_q[2]) begin
				pin_level_q <= pin_sync_q[2];
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			up_count_value_q <= {CNT_W{1'b0}};
		end else if (!counter_run_bit_q) begin
			up_count_value_q <= {CNT_W{1'b0}};
		end else if (step) begin
			if (clr1) begin
				up_count_value_q <= {CNT_W{1'b0}};
			end else begin
				up_count_value_q <= cnt_inc;
			end
		end
	end

	// AXI4-Lite write: address and data taken in either order.
	assign wr_ok = (aw_addr_q == `PUC_ADDR_RUN) || (aw_addr_q == `PUC_ADDR_MODE)
		|| (aw_addr_q == `PUC_ADDR_PRE) || (aw_addr_q == `PUC_ADDR_RG0)
		|| (aw_addr_q == `PUC_ADDR_RG1) || (aw_addr_q == `PUC_ADDR_IEN)
		|| (aw_addr_q == `PUC_ADDR_ICLR);

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PUC_RESP_OKAY;
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_q     <= s_axi_awaddr;
				aw_have_q     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
				w_have_q     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `PUC_RESP_OKAY : `PUC_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			counter_run_bit_q     <= 1'b0;
			prescaler_run_bit_q   <= 1'b0;
			count_source_select_q <= `PUC_SRC_DIV1;
			match1_clear_enable_q <= 1'b0;
			pre_sel_q             <= 3'h0;
			compare_reg_0_q       <= {CNT_W{1'b0}};
			compare_reg_1_q       <= {CNT_W{1'b0}};
			ien_q                 <= 3'h0;
		end else if (do_write && w_strb_q[0]) begin
			if (aw_addr_q == `PUC_ADDR_RUN) begin
				counter_run_bit_q   <= w_data_q[`PUC_RUN_CNT];
				prescaler_run_bit_q <= w_data_q[`PUC_RUN_PRE];
			end else if (aw_addr_q == `PUC_ADDR_MODE) begin
				count_source_select_q <=
					w_data_q[`PUC_MODE_SRC_HI:`PUC_MODE_SRC_LO];
				match1_clear_enable_q <= w_data_q[`PUC_MODE_CLE];
			end else if (aw_addr_q == `PUC_ADDR_PRE) begin
				pre_sel_q <= w_data_q[2:0];
			end else if (aw_addr_q == `PUC_ADDR_RG0) begin
				compare_reg_0_q <= w_data_q[CNT_W-1:0];
			end else if (aw_addr_q == `PUC_ADDR_RG1) begin
				compare_reg_1_q <= w_data_q[CNT_W-1:0];
			end else if (aw_addr_q == `PUC_ADDR_IEN) begin
				ien_q <= w_data_q[2:0];
			end
		end
	end

	// A new event in the clearing cycle keeps its flag set.
	wire [2:0] clr_mask = (do_write && w_strb_q[0]
		&& aw_addr_q == `PUC_ADDR_ICLR) ? w_data_q[2:0] : 3'h0;

	always @(posedge aclk) begin
		if (!aresetn) begin
			stat_q <= 3'h0;
			irq_q  <= 1'b0;
		end else begin
			stat_q <= (stat_q & ~clr_mask) | ev;
			irq_q  <= |(((stat_q & ~clr_mask) | ev) & ien_q);
		end
	end

	always @* begin
		rd_data = 32'h0000_0000;
		rd_ok   = 1'b1;
		if (s_axi_araddr == `PUC_ADDR_RUN) begin
			rd_data[`PUC_RUN_CNT] = counter_run_bit_q;
			rd_data[`PUC_RUN_PRE] = prescaler_run_bit_q;
		end else if (s_axi_araddr == `PUC_ADDR_MODE) begin
			rd_data[`PUC_MODE_SRC_HI:`PUC_MODE_SRC_LO] = count_source_select_q;
			rd_data[`PUC_MODE_CLE] = match1_clear_enable_q;
		end else if (s_axi_araddr == `PUC_ADDR_PRE) begin
			rd_data[2:0] = pre_sel_q;
		end else if (s_axi_araddr == `PUC_ADDR_RG0) begin
			rd_data[CNT_W-1:0] = compare_reg_0_q;
		end else if (s_axi_araddr == `PUC_ADDR_RG1) begin
			rd_data[CNT_W-1:0] = compare_reg_1_q;
		end else if (s_axi_araddr == `PUC_ADDR_CNT) begin
			rd_data[CNT_W-1:0] = up_count_value_q;
		end else if (s_axi_araddr == `PUC_ADDR_STAT) begin
			rd_data[2:0] = stat_q;
		end else if (s_axi_araddr == `PUC_ADDR_IEN) begin
			rd_data[2:0] = ien_q;
		end else if (s_axi_araddr == `PUC_ADDR_ICLR) begin
			rd_data = 32'h0000_0000;
		end else begin
			rd_ok = 1'b0;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `PUC_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_data;
				s_axi_rresp   <= rd_ok ? `PUC_RESP_OKAY : `PUC_RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire
